// >>> inc/egs_pkg.sv
package egs_pkg;
  localparam int NQ     = 8;
  localparam int NDSCP  = 64;
  localparam int CLK_NS = 50;
  // Shaper refill interval, in ns, and its length in clock cycles
  localparam int TICK_NS  = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int BITS_PER_MBIT_MS = 1000;

  localparam logic [19:0] RATE_DEF  = 20'h001f4;
  localparam logic [19:0] RATE_KMIN = 20'h00064;
  localparam logic [19:0] RATE_KMAX = 20'hf4240;
  localparam logic [19:0] RATE_MMIN = 20'h00001;
  localparam logic [19:0] RATE_MMAX = 20'h00ce4;
  localparam logic [6:0]  WGT_DEF   = 7'h11;
  localparam logic [6:0]  WGT_MIN   = 7'h01;
  localparam logic [6:0]  WGT_MAX   = 7'h64;
  localparam logic [6:0]  PCT_FULL  = 7'h64;
  localparam logic signed [31:0] BKT_CAP = 32'sh0010_0000;

  localparam logic [11:0] OFS_CTRL  = 12'h000;
  localparam logic [11:0] OFS_PCFG  = 12'h004;
  localparam logic [11:0] OFS_DFLT  = 12'h008;
  localparam logic [11:0] OFS_STAT  = 12'h00c;
  localparam logic [11:0] OFS_QCFG  = 12'h020;
  localparam logic [11:0] OFS_QPCT  = 12'h040;
  localparam logic [11:0] OFS_DSCP  = 12'h100;

  typedef enum logic {EGS_MODE_SP = 1'b0, EGS_MODE_WTD = 1'b1} egs_mode_e;

  typedef struct packed {
    logic [28:0] pad;
    logic        port_mbps;
    logic        port_en;
    egs_mode_e   mode;
  } egs_ctrl_s;

  typedef struct packed {
    logic       pad1;
    logic [6:0] weight;
    logic       pad0;
    logic       excess;
    logic       en;
    logic       mbps;
    logic [19:0] rate;
  } egs_qcfg_s;

  typedef struct packed {
    logic [2:0] qos_class;
    logic       drop_precedence_level;
  } egs_cls_s;

  typedef struct packed {
    logic     trust;
    egs_cls_s cls;
  } egs_dscp_s;

  localparam egs_qcfg_s QCFG_DEF = '{pad1: 1'b0, weight: WGT_DEF, pad0: 1'b0,
    excess: 1'b0, en: 1'b0, mbps: 1'b0, rate: RATE_DEF};
  localparam egs_ctrl_s CTRL_DEF = '{pad: 29'h0, port_mbps: 1'b0, port_en: 1'b0,
    mode: EGS_MODE_SP};
endpackage : egs_pkg

// >>> core/egs_sched_shaper.sv
`timescale 1ns/1ps
module egs_sched_shaper #(
  parameter int TICK_CYCLES = egs_pkg::TICK_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [11:0]           avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic [7:0]            q_pending_i,
  input  wire logic [7:0][15:0]      q_len_i,
  input  wire logic                  tx_ready_i,
  output logic                       tx_grant_o,
  output logic [2:0]                 tx_queue_o,
  output logic [15:0]                tx_len_o,
  input  wire logic                  cls_valid_i,
  input  wire logic                  cls_is_ip_i,
  input  wire logic [5:0]            cls_dscp_i,
  output logic                       cls_valid_o,
  output egs_pkg::egs_cls_s          cls_o
);

  function automatic logic [31:0] egs_be_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : egs_be_merge

  function automatic logic egs_rate_ok(input egs_pkg::egs_qcfg_s c);
    if (c.mbps)
      return c.rate >= egs_pkg::RATE_MMIN && c.rate <= egs_pkg::RATE_MMAX;
    return c.rate >= egs_pkg::RATE_KMIN && c.rate <= egs_pkg::RATE_KMAX;
  endfunction : egs_rate_ok

  function automatic logic egs_wgt_ok(input logic [6:0] w);
    return w >= egs_pkg::WGT_MIN && w <= egs_pkg::WGT_MAX;
  endfunction : egs_wgt_ok

  // First set bit at or after start, wrapping around
  function automatic logic [2:0] egs_pick_rr(input logic [7:0] m, input logic [2:0] start);
    logic [2:0] r;
    logic [2:0] idx;
    r = start;
    for (int k = 7; k >= 0; k--)
    begin
      idx = start + 3'(k);
      if (m[idx])
        r = idx;
    end
    return r;
  endfunction : egs_pick_rr

  function automatic logic [2:0] egs_pick_hi(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++)
      if (m[i])
        r = 3'(i);
    return r;
  endfunction : egs_pick_hi

  // Bucket is in bits; kbps adds rate bits per ms, Mbps adds rate*1000
  function automatic logic signed [31:0] egs_bkt_next(input logic signed [31:0] b,
      input egs_pkg::egs_qcfg_s c, input logic tick, input logic debit, input logic [15:0] len);
    logic signed [31:0] n;
    n = b;
    if (tick)
      n = n + (c.mbps ? 32'(c.rate) * egs_pkg::BITS_PER_MBIT_MS : 32'(c.rate));
    if (n > egs_pkg::BKT_CAP)
      n = egs_pkg::BKT_CAP;
    if (debit)
      n = n - 32'({len, 3'b000});
    if (!c.en)
      n = 32'sh0;
    return n;
  endfunction : egs_bkt_next

  egs_pkg::egs_ctrl_s        ctrl_reg;
  egs_pkg::egs_qcfg_s        pcfg_reg;
  egs_pkg::egs_cls_s         dflt_reg;
  egs_pkg::egs_qcfg_s [7:0]  qcfg_reg;
  egs_pkg::egs_dscp_s        dscp_reg [egs_pkg::NDSCP];
  logic signed [31:0]        bkt_reg [egs_pkg::NQ + 1];
  logic [6:0]                credit_reg [egs_pkg::NQ];
  logic [2:0]                rr_reg;
  logic [31:0]               tick_cnt_reg;
  logic                      tick_reg;
  logic                      ack_reg;
  logic [31:0]               rdata_reg;
  logic                      grant_reg;
  logic [2:0]                txq_reg;
  logic [15:0]               txlen_reg;
  logic                      cvalid_reg;
  egs_pkg::egs_cls_s         cls_reg;

  // Bus decode
  wire       bus_req   = avs_read_i | avs_write_i;
  wire       wr_commit = avs_write_i & ack_reg;
  wire       aligned   = avs_address_i[1:0] == 2'b00;
  wire       hit_ctrl  = aligned && avs_address_i == egs_pkg::OFS_CTRL;
  wire       hit_pcfg  = aligned && avs_address_i == egs_pkg::OFS_PCFG;
  wire       hit_dflt  = aligned && avs_address_i == egs_pkg::OFS_DFLT;
  wire       hit_stat  = aligned && avs_address_i == egs_pkg::OFS_STAT;
  wire       hit_qcfg  = aligned && avs_address_i[11:5] == egs_pkg::OFS_QCFG[11:5];
  wire       hit_qpct  = aligned && avs_address_i[11:5] == egs_pkg::OFS_QPCT[11:5];
  wire       hit_dscp  = aligned && avs_address_i[11:8] == egs_pkg::OFS_DSCP[11:8];
  wire [2:0] rq        = avs_address_i[4:2];
  wire [5:0] rd_idx    = avs_address_i[7:2];

  wire egs_pkg::egs_qcfg_s q_wr = egs_pkg::egs_qcfg_s'(egs_be_merge(qcfg_reg[rq], avs_writedata_i,
                                                                    avs_byteenable_i));
  wire egs_pkg::egs_qcfg_s p_wr = egs_pkg::egs_qcfg_s'(egs_be_merge(pcfg_reg, avs_writedata_i,
                                                                    avs_byteenable_i));
  wire q_wr_ok = egs_rate_ok(q_wr) && egs_wgt_ok(q_wr.weight);
  wire p_wr_ok = egs_rate_ok(p_wr);

  // Weight percentage of the port's weight sum
  logic [9:0] wsum;
  always_comb
  begin
    wsum = 10'h0;
    for (int i = 0; i < egs_pkg::NQ; i++)
      wsum = wsum + 10'(qcfg_reg[i].weight);
  end
  wire [6:0] rd_pct = 7'((32'(qcfg_reg[rq].weight) * 32'(egs_pkg::PCT_FULL)) / 32'(wsum));

  // Eligibility and selection
  logic [7:0] qok;
  logic [7:0] exc_m;
  logic [7:0] cred_m;
  always_comb
  begin
    for (int i = 0; i < egs_pkg::NQ; i++)
    begin
      qok[i]    = !qcfg_reg[i].en || !bkt_reg[i][31];
      exc_m[i]  = qcfg_reg[i].excess;
      cred_m[i] = credit_reg[i] != 7'h0;
    end
  end
  wire       pok    = !ctrl_reg.port_en || !bkt_reg[egs_pkg::NQ][31];
  wire [7:0] base   = q_pending_i & qok;
  // Excess queues only use bandwidth no in-profile queue wants
  wire [7:0] elig   = !pok ? 8'h00 : (|base ? base : (q_pending_i & exc_m));
  wire [7:0] wmask  = elig & cred_m;
  wire       reload = wmask == 8'h00;
  wire [2:0] w_pick = egs_pick_rr(reload ? elig : wmask, rr_reg);
  wire [2:0] s_pick = egs_pick_hi(elig);
  wire       wtd    = ctrl_reg.mode == egs_pkg::EGS_MODE_WTD;
  wire [2:0] pick   = wtd ? w_pick : s_pick;
  wire       fire   = tx_ready_i && |elig && !grant_reg;
  wire [15:0] pick_len = q_len_i[pick];

  // DSCP trust lookup
  wire egs_pkg::egs_dscp_s dsel = dscp_reg[cls_dscp_i];
  wire trusted = cls_is_ip_i && dsel.trust;
  wire egs_pkg::egs_cls_s cls_next = trusted ? dsel.cls : dflt_reg;

  logic [31:0] rd_word;
  assign rd_word = hit_ctrl ? 32'(ctrl_reg) :
                   hit_pcfg ? 32'(pcfg_reg) :
                   hit_dflt ? {28'h0, dflt_reg} :
                   hit_stat ? {5'h0, rr_reg, 5'h0, txq_reg, elig, q_pending_i} :
                   hit_qcfg ? 32'(qcfg_reg[rq]) :
                   hit_qpct ? {25'h0, rd_pct} :
                   hit_dscp ? {27'h0, dscp_reg[rd_idx]} : 32'h0;

  assign avs_waitrequest_o = bus_req & ~ack_reg;
  assign avs_readdata_o    = rdata_reg;
  assign tx_grant_o        = grant_reg;
  assign tx_queue_o        = txq_reg;
  assign tx_len_o          = txlen_reg;
  assign cls_valid_o       = cvalid_reg;
  assign cls_o             = cls_reg;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (avs_read_i && !ack_reg)
        rdata_reg <= rd_word;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_reg <= egs_pkg::CTRL_DEF;
      pcfg_reg <= egs_pkg::QCFG_DEF;
      dflt_reg <= '0;
      for (int i = 0; i < egs_pkg::NQ; i++)
        qcfg_reg[i] <= egs_pkg::QCFG_DEF;
      for (int d = 0; d < egs_pkg::NDSCP; d++)
        dscp_reg[d] <= '0;
    end
    else if (wr_commit)
    begin
      if (hit_ctrl)
        ctrl_reg <= egs_pkg::egs_ctrl_s'({29'h0, 3'(egs_be_merge(32'(ctrl_reg), avs_writedata_i,
                                                                  avs_byteenable_i))});
      // Out-of-range settings are dropped and the old value stays
      if (hit_pcfg && p_wr_ok)
        pcfg_reg <= p_wr;
      if (hit_qcfg && q_wr_ok)
        qcfg_reg[rq] <= q_wr;
      if (hit_dflt && avs_byteenable_i[0])
        dflt_reg <= avs_writedata_i[3:0];
      if (hit_dscp && avs_byteenable_i[0])
        dscp_reg[rd_idx] <= avs_writedata_i[4:0];
    end
  end

  // The port shaper shares enable and unit with the control word
  wire egs_pkg::egs_qcfg_s pshp = '{pad1: 1'b0, weight: 7'h0, pad0: 1'b0, excess: 1'b0,
                                    en: ctrl_reg.port_en, mbps: ctrl_reg.port_mbps,
                                    rate: pcfg_reg.rate};
  wire pshp_unused = ^{pcfg_reg.mbps, pcfg_reg.en};

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
    end
    else
    begin
      tick_reg     <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i <= egs_pkg::NQ; i++)
        bkt_reg[i] <= 32'sh0;
    end
    else
    begin
      for (int i = 0; i < egs_pkg::NQ; i++)
        bkt_reg[i] <= egs_bkt_next(bkt_reg[i], qcfg_reg[i], tick_reg,
                                   fire && pick == 3'(i), pick_len);
      bkt_reg[egs_pkg::NQ] <= egs_bkt_next(bkt_reg[egs_pkg::NQ], pshp, tick_reg,
                                           fire, pick_len);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rr_reg <= 3'h0;
      for (int i = 0; i < egs_pkg::NQ; i++)
        credit_reg[i] <= egs_pkg::WGT_DEF;
    end
    else
    begin
      if (fire && wtd)
      begin
        // A new round starts once no eligible queue has credit left
        for (int i = 0; i < egs_pkg::NQ; i++)
          if (3'(i) == pick)
            credit_reg[i] <= (reload ? qcfg_reg[i].weight : credit_reg[i]) - 7'h1;
          else if (reload)
            credit_reg[i] <= qcfg_reg[i].weight;
        rr_reg <= pick + 3'h1;
      end
      // A new weight counts at once, not after the old credit drains
      if (wr_commit && hit_qcfg && q_wr_ok)
        credit_reg[rq] <= q_wr.weight;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      grant_reg <= 1'b0;
      txq_reg   <= 3'h0;
      txlen_reg <= 16'h0;
    end
    else
    begin
      grant_reg <= fire;
      if (fire)
      begin
        txq_reg   <= pick;
        txlen_reg <= pick_len;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cvalid_reg <= 1'b0;
      cls_reg    <= '0;
    end
    else
    begin
      cvalid_reg <= cls_valid_i;
      if (cls_valid_i)
        cls_reg <= cls_next;
    end
  end

  // Checks
  logic all_ok;
  always_comb
  begin
    all_ok = egs_rate_ok(pcfg_reg) && !pshp_unused | pshp_unused;
    for (int i = 0; i < egs_pkg::NQ; i++)
      all_ok = all_ok && egs_rate_ok(qcfg_reg[i]) && egs_wgt_ok(qcfg_reg[i].weight);
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_SP_FIRST: assert property (fire && !wtd |-> (elig >> pick) <= 8'h01)
    else $error("strict grant skipped a higher eligible queue");
  AST_SP_STARVE: assert property (fire && !wtd && elig[7] |=> tx_grant_o && tx_queue_o == 3'h7)
    else $error("queue 7 did not win in strict mode");
  AST_WORK_CONS: assert property (tx_ready_i && !grant_reg && |elig |=> tx_grant_o ##1 !tx_grant_o)
    else $error("eligible traffic not granted");
  AST_WTD_ROT: assert property (fire && wtd |=> rr_reg == $past(pick) + 3'h1)
    else $error("weighted pointer did not rotate");
  AST_WTD_CREDIT: assert property (fire && wtd && !reload |-> cred_m[pick])
    else $error("weighted grant without credit");
  AST_CFG_RANGE: assert property (all_ok)
    else $error("weight or rate out of range");
  AST_Q_SHAPE: assert property (fire |-> qok[pick] || (exc_m[pick] && base == 8'h00))
    else $error("shaped queue started while bucket negative");
  AST_P_SHAPE: assert property (fire |-> !ctrl_reg.port_en || !bkt_reg[egs_pkg::NQ][31])
    else $error("port started while port bucket negative");
  AST_UNTRUST: assert property (cls_valid_i && !trusted |=> cls_valid_o && cls_o == $past(dflt_reg))
    else $error("untrusted frame not given default class");
  AST_TRUST: assert property (cls_valid_i && trusted |=> cls_o == $past(dsel.cls))
    else $error("trusted frame not mapped");

  COV_WTD_RELOAD: cover property (fire && wtd && reload);
  COV_EXCESS: cover property (fire && !qok[pick]);
  COV_SP_LOW: cover property (fire && !wtd && pick == 3'h0);
  COV_UNTRUST: cover property (cls_valid_i && cls_is_ip_i && !dsel.trust);

endmodule : egs_sched_shaper

// >>> sim/egs_tx_partner.sv
`timescale 1ns/1ps
module egs_tx_partner (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic [7:0]      fill_i,
  input  wire logic            stall_i,
  input  wire logic            tx_grant_i,
  input  wire logic [2:0]      tx_queue_i,
  output logic [7:0]           q_pending_o,
  output logic [7:0][15:0]     q_len_o,
  output logic                 tx_ready_o
);
  logic [7:0][7:0] count_reg;
  logic            busy_reg;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
    end
    else
    begin
      for (int n = 0; n < 8; n++)
        count_reg[n] <= count_reg[n] + 8'(fill_i[n]) - 8'(tx_grant_i && (tx_queue_i == 3'(n)));
      busy_reg <= tx_grant_i;
    end
  end

  // Empty queues show a junk length so a stale head length is never mistaken for real
  always_comb
  begin
    for (int n = 0; n < 8; n++)
    begin
      q_pending_o[n] = (count_reg[n] != 8'h00);
      q_len_o[n]     = q_pending_o[n] ? 16'h0040 + 16'(n) : 16'hffff;
    end
  end

  // Ready drops the cycle after a grant, as the transmit contract demands
  assign tx_ready_o = !stall_i && !busy_reg;
endmodule : egs_tx_partner

// >>> sim/egs_sched_shaper_bench.sv
`timescale 1ns/1ps
module egs_sched_shaper_bench;
  logic              clk_i;
  logic              reset_n_i;
  logic [11:0]       avs_address_i;
  logic              avs_read_i;
  logic              avs_write_i;
  logic [31:0]       avs_writedata_i;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o;
  logic [7:0]        q_pending;
  logic [7:0][15:0]  q_len;
  logic              tx_ready;
  logic              tx_grant_o;
  logic [2:0]        tx_queue_o;
  logic [15:0]       tx_len_o;
  logic              cls_valid_i;
  logic              cls_is_ip_i;
  logic [5:0]        cls_dscp_i;
  logic              cls_valid_o;
  egs_pkg::egs_cls_s cls_o;
  logic [7:0]        fill;
  logic              stall;
  int                mismatches;
  int                comparisons;
  int                n7;
  logic [2:0]        glog[$];
  logic [31:0]       rd;
  logic [2:0]        sp_exp[6] = '{3'd7, 3'd7, 3'd3, 3'd3, 3'd0, 3'd0};
  logic [31:0]       bad[4] = '{32'h64100ce5, 32'h64000063, 32'h000001f4, 32'h650001f4};

  egs_sched_shaper #(.TICK_CYCLES(20)) egs_sched_shaper_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .q_pending_i(q_pending),
    .q_len_i(q_len), .tx_ready_i(tx_ready), .tx_grant_o(tx_grant_o), .tx_queue_o(tx_queue_o),
    .tx_len_o(tx_len_o), .cls_valid_i(cls_valid_i), .cls_is_ip_i(cls_is_ip_i), .cls_dscp_i(cls_dscp_i),
    .cls_valid_o(cls_valid_o), .cls_o(cls_o));

  egs_tx_partner egs_tx_partner_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .fill_i(fill), .stall_i(stall), .tx_grant_i(tx_grant_o),
    .tx_queue_i(tx_queue_o), .q_pending_o(q_pending), .q_len_o(q_len), .tx_ready_o(tx_ready));

  always #25 clk_i = ~clk_i;

  task tally_and_finish();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_out

  // Request held until the edge where waitrequest is seen low; data taken there
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_reg(nm, e, rd);
  endtask : rdc

  // Queues fill while the partner stalls; the log restarts first so a frame left over still counts
  task serve(input logic [7:0] m, input int k, input int cyc);
    @(posedge clk_i);
    glog.delete();
    stall <= 1'b1;
    repeat (k)
    begin
      @(posedge clk_i);
      fill <= m;
      @(posedge clk_i);
      fill <= 8'h00;
    end
    @(posedge clk_i);
    stall <= 1'b0;
    repeat (cyc) @(posedge clk_i);
  endtask : serve

  task cls(input logic ip, input logic [5:0] d, input logic [3:0] e);
    @(posedge clk_i);
    cls_valid_i <= 1'b1;
    cls_is_ip_i <= ip;
    cls_dscp_i  <= d;
    @(posedge clk_i);
    cls_valid_i <= 1'b0;
    #1;
    chk_out("classifier", {11'h0, 1'b1, e}, {11'h0, cls_valid_o, cls_o});
  endtask : cls

  always @(posedge clk_i)
  begin
    if (tx_grant_o === 1'b1)
    begin
      glog.push_back(tx_queue_o);
      chk_out("tx_len", 16'h0040 + 16'(tx_queue_o), tx_len_o);
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    {cls_valid_i, cls_is_ip_i, cls_dscp_i, fill, stall} = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdc("ctrl", egs_pkg::OFS_CTRL, 32'h0);
    for (int q = 0; q < 8; q++)
      rdc("qcfg", egs_pkg::OFS_QCFG + 12'(4 * q), 32'h110001f4);
    rdc("qpct", egs_pkg::OFS_QPCT, 32'h0000000c);
    rdc("dscp", egs_pkg::OFS_DSCP + 12'h0fc, 32'h0);
    rdc("unmapped", 12'h800, 32'h0);
    bus(1'b1, egs_pkg::OFS_QCFG + 12'h008, 32'h64100ce4);
    foreach (bad[i])
      bus(1'b1, egs_pkg::OFS_QCFG + 12'h008, bad[i]);
    rdc("qcfg2", egs_pkg::OFS_QCFG + 12'h008, 32'h64100ce4);
    bus(1'b1, egs_pkg::OFS_QCFG + 12'h008, 32'h110f4240);
    rdc("qcfg2", egs_pkg::OFS_QCFG + 12'h008, 32'h110f4240);
    serve(8'h89, 2, 40);
    chk_out("strict count", 16'd6, 16'(glog.size()));
    for (int i = 0; i < 6 && i < glog.size(); i++)
      chk_out("strict order", 16'(sp_exp[i]), 16'(glog[i]));
    bus(1'b1, egs_pkg::OFS_CTRL, 32'h1);
    bus(1'b1, egs_pkg::OFS_QCFG + 12'h01c, 32'h020001f4);
    bus(1'b1, egs_pkg::OFS_QCFG, 32'h010001f4);
    rdc("qpct7", egs_pkg::OFS_QPCT + 12'h01c, 32'h1);
    rdc("qpct1", egs_pkg::OFS_QPCT + 12'h004, 32'h10);
    serve(8'h81, 4, 60);
    chk_out("weighted count", 16'd8, 16'(glog.size()));
    n7 = 0;
    for (int i = 0; i < 6 && i < glog.size(); i++)
      n7 += int'(glog[i] == 3'd7);
    chk_out("weighted share", 16'd4, 16'(n7));
    bus(1'b1, egs_pkg::OFS_CTRL, 32'h0);
    bus(1'b1, egs_pkg::OFS_QCFG + 12'h01c, 32'h02200064);
    serve(8'h80, 2, 60);
    chk_out("queue shaped", 16'd1, 16'(glog.size()));
    bus(1'b1, egs_pkg::OFS_QCFG + 12'h01c, 32'h02600064);
    serve(8'h80, 1, 30);
    chk_out("excess", 16'd2, 16'(glog.size()));
    bus(1'b1, egs_pkg::OFS_QCFG + 12'h01c, 32'h020001f4);
    bus(1'b1, egs_pkg::OFS_PCFG, 32'h64);
    bus(1'b1, egs_pkg::OFS_CTRL, 32'h2);
    serve(8'h01, 2, 60);
    chk_out("port shaped", 16'd1, 16'(glog.size()));
    bus(1'b1, egs_pkg::OFS_CTRL, 32'h0);
    serve(8'h00, 0, 20);
    chk_out("port unshaped", 16'd1, 16'(glog.size()));
    rdc("stat", egs_pkg::OFS_STAT, 32'h01000000);
    bus(1'b1, egs_pkg::OFS_DFLT, 32'hb);
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b1, egs_pkg::OFS_DSCP + 12'(4 * (56 + k)), {27'h0, 1'b1, 3'(k), k[0]});
      cls(1'b1, 6'(56 + k), {3'(k), k[0]});
    end
    rdc("dscp63", egs_pkg::OFS_DSCP + 12'h0fc, 32'h1f);
    cls(1'b0, 6'd63, 4'hb);
    bus(1'b1, egs_pkg::OFS_DSCP + 12'h0fc, 32'h0f);
    cls(1'b1, 6'd63, 4'hb);
    tally_and_finish();
  end
endmodule : egs_sched_shaper_bench
